/* hdl/qdac_cfg.svh */
// constants for the quad converter parallel-port host
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH

// bus widths and channel count
`define QDAC_DATA_W 8
`define QDAC_CH_W 2
`define QDAC_NCH 4

// channel select codes, upper bit on the high select line
`define QDAC_CH_A 2'h0
`define QDAC_CH_B 2'h1
`define QDAC_CH_C 2'h2
`define QDAC_CH_D 2'h3

// clock period and strobe timing in ns
`define QDAC_CLK_NS 20
`define QDAC_T_SETUP_NS 20
`define QDAC_T_WR_NS 40
`define QDAC_T_HOLD_NS 20
`define QDAC_T_LD_NS 40

// least times round up to whole cycles
`define QDAC_CYC(ns) (((ns) + `QDAC_CLK_NS - 1) / `QDAC_CLK_NS)
`define QDAC_SETUP_CYC `QDAC_CYC(`QDAC_T_SETUP_NS)
`define QDAC_WR_CYC `QDAC_CYC(`QDAC_T_WR_NS)
`define QDAC_HOLD_CYC `QDAC_CYC(`QDAC_T_HOLD_NS)
`define QDAC_LD_CYC `QDAC_CYC(`QDAC_T_LD_NS)

// counter width and idle pin levels
`define QDAC_CNT_W 4
`define QDAC_STROBE_IDLE 1'h1
`define QDAC_DATA_RST 8'h00

`endif

/* hdl/qdac_pkg.sv */
// types for the quad converter parallel-port host
package qdac_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_LOAD,
		ST_PDOWN
	} qdac_state_e;

	typedef logic [1:0] qdac_ch_t;
	typedef logic [7:0] qdac_code_t;
	typedef logic [3:0] qdac_cnt_t;

endpackage

/* hdl/qdac_shadow.sv */
// shadow copy of the four channel codes last written
`timescale 1ns/1ps

module qdac_shadow #(
	parameter int DW = 8,
	parameter int AW = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_r;
	logic [DW-1:0] rdata_nxt;

	// write data goes straight through so a read of the same entry is fresh
	always_comb begin
		rdata_nxt = mem[raddr];
		if (we && waddr == raddr) begin
			rdata_nxt = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

endmodule

/* hdl/qdac_host.sv */
// host controller driving the quad converter parallel load port
//
// Summary of operation
// - the host pulls the write strobe low to load the addressed register.
// - the data bus is eight bits, highest line most significant.
// - two select lines pick a register; the low one is also power-down.
// - the device shuts down when the host floats the low select line.
// - select codes 00..11 pick channels A..D, high line as upper bit.
`timescale 1ns/1ps
`include "qdac_cfg.svh"

module qdac_host (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// command
	input wire logic cmd_write,
	input wire logic cmd_update,
	input wire logic [`QDAC_CH_W-1:0] cmd_channel,
	input wire logic [`QDAC_DATA_W-1:0] cmd_data,
	output logic cmd_ready,
	// power control
	input wire logic cmd_power_down,
	output logic power_down,
	// shadow readback
	input wire logic [`QDAC_CH_W-1:0] rd_channel,
	output logic [`QDAC_DATA_W-1:0] rd_data,
	// device pins
	output logic wr_n,
	output logic dac_update_strobe_n,
	output logic reg_select_hi,
	output logic reg_select_lo_powerdown_o,
	output logic reg_select_lo_powerdown_oe,
	output logic [`QDAC_DATA_W-1:0] parallel_data_bus
);

	// ==========================================================
	// helpers
	function automatic qdac_pkg::qdac_cnt_t cnt_load(input int cyc);
		cnt_load = `QDAC_CNT_W'(cyc - 1);
	endfunction

	// ==========================================================
	// state
	qdac_pkg::qdac_state_e state_r, state_nxt;
	qdac_pkg::qdac_cnt_t cnt_r, cnt_nxt;
	logic upd_pend_r, upd_pend_nxt;
	logic ready_r, ready_nxt;
	logic pd_r, pd_nxt;
	logic wr_n_r, wr_n_nxt;
	logic ld_n_r, ld_n_nxt;
	logic sel_hi_r, sel_hi_nxt;
	logic sel_lo_r, sel_lo_nxt;
	logic lo_oe_r, lo_oe_nxt;
	logic [`QDAC_DATA_W-1:0] bus_r, bus_nxt;
	logic accept;
	logic mem_we;

	assign accept = ready_r && (cmd_write || cmd_update) && !cmd_power_down;
	// the input register has latched once the write strobe rises
	assign mem_we = state_r == qdac_pkg::ST_STROBE && cnt_r == '0;

	// ==========================================================
	// sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		upd_pend_nxt = upd_pend_r;
		ready_nxt = ready_r;
		pd_nxt = pd_r;
		wr_n_nxt = wr_n_r;
		ld_n_nxt = ld_n_r;
		sel_hi_nxt = sel_hi_r;
		sel_lo_nxt = sel_lo_r;
		lo_oe_nxt = lo_oe_r;
		bus_nxt = bus_r;
		unique case (state_r)
			qdac_pkg::ST_IDLE: begin
				if (cmd_power_down) begin
					lo_oe_nxt = 1'b0;
					pd_nxt = 1'b1;
					ready_nxt = 1'b0;
					state_nxt = qdac_pkg::ST_PDOWN;
				end else if (accept && cmd_write) begin
					sel_hi_nxt = cmd_channel[1];
					sel_lo_nxt = cmd_channel[0];
					lo_oe_nxt = 1'b1;
					bus_nxt = cmd_data;
					upd_pend_nxt = cmd_update;
					ready_nxt = 1'b0;
					cnt_nxt = cnt_load(`QDAC_SETUP_CYC);
					state_nxt = qdac_pkg::ST_SETUP;
				end else if (accept) begin
					ld_n_nxt = 1'b0;
					ready_nxt = 1'b0;
					cnt_nxt = cnt_load(`QDAC_LD_CYC);
					state_nxt = qdac_pkg::ST_LOAD;
				end
			end
			qdac_pkg::ST_SETUP: begin
				if (cnt_r == '0) begin
					wr_n_nxt = 1'b0;
					cnt_nxt = cnt_load(`QDAC_WR_CYC);
					state_nxt = qdac_pkg::ST_STROBE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			qdac_pkg::ST_STROBE: begin
				if (cnt_r == '0) begin
					wr_n_nxt = 1'b1;
					cnt_nxt = cnt_load(`QDAC_HOLD_CYC);
					state_nxt = qdac_pkg::ST_HOLD;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			qdac_pkg::ST_HOLD: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (upd_pend_r) begin
					// load strobe only after the write strobe is back high
					ld_n_nxt = 1'b0;
					upd_pend_nxt = 1'b0;
					cnt_nxt = cnt_load(`QDAC_LD_CYC);
					state_nxt = qdac_pkg::ST_LOAD;
				end else begin
					ready_nxt = 1'b1;
					state_nxt = qdac_pkg::ST_IDLE;
				end
			end
			qdac_pkg::ST_LOAD: begin
				if (cnt_r == '0) begin
					ld_n_nxt = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = qdac_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			qdac_pkg::ST_PDOWN: begin
				// writes are refused here since driving the line would wake it
				if (!cmd_power_down) begin
					lo_oe_nxt = 1'b1;
					pd_nxt = 1'b0;
					ready_nxt = 1'b1;
					state_nxt = qdac_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = qdac_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= qdac_pkg::ST_IDLE;
			cnt_r <= '0;
			upd_pend_r <= 1'b0;
			ready_r <= 1'b1;
			pd_r <= 1'b0;
			wr_n_r <= `QDAC_STROBE_IDLE;
			ld_n_r <= `QDAC_STROBE_IDLE;
			sel_hi_r <= 1'b0;
			sel_lo_r <= 1'b0;
			lo_oe_r <= 1'b1;
			bus_r <= `QDAC_DATA_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			upd_pend_r <= upd_pend_nxt;
			ready_r <= ready_nxt;
			pd_r <= pd_nxt;
			wr_n_r <= wr_n_nxt;
			ld_n_r <= ld_n_nxt;
			sel_hi_r <= sel_hi_nxt;
			sel_lo_r <= sel_lo_nxt;
			lo_oe_r <= lo_oe_nxt;
			bus_r <= bus_nxt;
		end
	end

	// ==========================================================
	// shadow store
	qdac_shadow #(
		.DW(`QDAC_DATA_W),
		.AW(`QDAC_CH_W)
	) u_shadow (
		.clk(clk),
		.reset(reset),
		.we(mem_we),
		.waddr({sel_hi_r, sel_lo_r}),
		.wdata(bus_r),
		.raddr(rd_channel),
		.rdata(rd_data)
	);

	// ==========================================================
	// outputs
	assign cmd_ready = ready_r;
	assign power_down = pd_r;
	assign wr_n = wr_n_r;
	assign dac_update_strobe_n = ld_n_r;
	assign reg_select_hi = sel_hi_r;
	assign reg_select_lo_powerdown_o = sel_lo_r;
	assign reg_select_lo_powerdown_oe = lo_oe_r;
	assign parallel_data_bus = bus_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_wr_width;
		$fell(wr_n_r) |-> !wr_n_r ##1 !wr_n_r ##1 wr_n_r;
	endproperty
	a_wr_width: assert property (p_wr_width)
		else $error("write strobe width wrong");

	property p_bus_order;
		accept && cmd_write |=> bus_r == $past(cmd_data);
	endproperty
	a_bus_order: assert property (p_bus_order)
		else $error("data bus differs from command data");

	property p_sel_map;
		accept && cmd_write |=> {sel_hi_r, sel_lo_r} == $past(cmd_channel);
	endproperty
	a_sel_map: assert property (p_sel_map)
		else $error("select lines do not match channel");

	property p_addr_stable;
		!wr_n_r |=> $stable({sel_hi_r, sel_lo_r, bus_r}) && lo_oe_r;
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("select or data moved around write strobe");

	property p_pd_float;
		pd_r |-> !lo_oe_r && wr_n_r && ld_n_r;
	endproperty
	a_pd_float: assert property (p_pd_float)
		else $error("select line driven during shutdown");

	property p_pd_enter;
		state_r == qdac_pkg::ST_IDLE && cmd_power_down |=> pd_r && !lo_oe_r;
	endproperty
	a_pd_enter: assert property (p_pd_enter)
		else $error("shutdown request not honoured");

	property p_ld_after_wr;
		$fell(ld_n_r) |-> wr_n_r ##1 !ld_n_r ##1 ld_n_r;
	endproperty
	a_ld_after_wr: assert property (p_ld_after_wr)
		else $error("load strobe overlapped write or wrong width");

	c_write: cover property ($rose(wr_n_r));
	c_update: cover property ($rose(ld_n_r));
	c_pdown: cover property ($rose(pd_r) ##[1:20] $fell(pd_r));

endmodule

/* test/qdac_dev.sv */
// behavioural model of the quad converter parallel load port
`timescale 1ns/1ps

module qdac_dev (
	// host pins
	input wire logic wr_n,
	input wire logic dac_update_strobe_n,
	input wire logic reg_select_hi,
	input wire logic sel_lo,
	input wire logic sel_lo_oe,
	input wire logic [7:0] parallel_data_bus,
	// analog side
	output logic power_down,
	output wire logic [31:0] channel_output
);
	logic [7:0] inr [4];
	logic [7:0] dacr [4];
	wire lo_line = sel_lo_oe ? sel_lo : 1'bz;

	// ==========
	// select and latches
	// float detect
	assign power_down = !sel_lo_oe;
	// host pins come from flip-flops, so edges arrive clean
	always @(wr_n, reg_select_hi, lo_line, parallel_data_bus, power_down) begin
		if (!wr_n && !power_down)
			inr[{reg_select_hi, lo_line}] = parallel_data_bus;
	end
	always @(dac_update_strobe_n, inr[0], inr[1], inr[2], inr[3]) begin
		if (!dac_update_strobe_n)
			for (int i = 0; i < 4; i++)
				dacr[i] = inr[i];
	end
	for (genvar g = 0; g < 4; g++) begin : g_out
		assign channel_output[g*8+:8] = power_down ? 8'hZZ : dacr[g];
	end
endmodule

/* test/testbench.sv */
// self-checking bench for the quad converter host
`timescale 1ns/1ps
`include "qdac_cfg.svh"

module testbench;
	logic clk, reset, cmd_write, cmd_update, cmd_power_down, cmd_ready;
	logic [1:0] cmd_channel, rd_channel;
	logic [7:0] cmd_data, rd_data, bus;
	logic pd, wr_n, ld_n, s_hi, s_lo, s_oe, dev_pd;
	logic [31:0] chan;
	logic [7:0] cur [4];
	int err_total, checked, wlow, llow;

	qdac_host DUT (.clk(clk), .reset(reset), .cmd_write(cmd_write),
		.cmd_update(cmd_update), .cmd_channel(cmd_channel),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.cmd_power_down(cmd_power_down), .power_down(pd),
		.rd_channel(rd_channel), .rd_data(rd_data), .wr_n(wr_n),
		.dac_update_strobe_n(ld_n), .reg_select_hi(s_hi),
		.reg_select_lo_powerdown_o(s_lo),
		.reg_select_lo_powerdown_oe(s_oe), .parallel_data_bus(bus));
	qdac_dev dev (.wr_n(wr_n), .dac_update_strobe_n(ld_n),
		.reg_select_hi(s_hi), .sel_lo(s_lo), .sel_lo_oe(s_oe),
		.parallel_data_bus(bus), .power_down(dev_pd),
		.channel_output(chan));

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// ==========
	// shared tasks
	task results;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	// one command, strobe widths counted until ready returns
	task run_cmd(input logic w, input logic u, input logic [1:0] ch,
		input logic [7:0] d);
		int n;
		wlow = 0;
		llow = 0;
		@(posedge clk);
		cmd_write <= w;
		cmd_update <= u;
		cmd_channel <= ch;
		cmd_data <= d;
		@(posedge clk);
		cmd_write <= 1'h0;
		cmd_update <= 1'h0;
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			wlow += (wr_n === 1'h0);
			llow += (ld_n === 1'h0);
			if (cmd_ready === 1'h1)
				break;
		end
		if (n == 20) begin
			err_total++;
			results();
		end
		chk8(8'(wlow), w ? 8'(`QDAC_WR_CYC) : 8'h00);
		chk8(8'(llow), u ? 8'(`QDAC_LD_CYC) : 8'h00);
	endtask

	// ==========
	// scenarios
	task t_reset;
		chk1(wr_n, 1'h1);
		chk1(ld_n, 1'h1);
		chk1(s_oe, 1'h1);
		chk1(dev_pd, 1'h0);
		chk1(cmd_ready, 1'h1);
	endtask
	task t_write_load;
		for (int c = 0; c < 4; c++) begin
			run_cmd(1'h1, 1'h1, 2'(c), cur[c]);
			chk8({6'h00, s_hi, s_lo}, 8'(c));
			chk8(bus, cur[c]);
			chk8(chan[c*8+:8], cur[c]);
		end
	endtask
	// preload all four, outputs move only on the load strobe
	task t_preload;
		for (int c = 0; c < 4; c++) begin
			run_cmd(1'h1, 1'h0, 2'(c), ~cur[c]);
			chk8(chan[c*8+:8], cur[c]);
		end
		run_cmd(1'h0, 1'h1, 2'h0, 8'h00);
		for (int c = 0; c < 4; c++) begin
			cur[c] = ~cur[c];
			chk8(chan[c*8+:8], cur[c]);
		end
	endtask
	task t_readback;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			rd_channel <= 2'(c);
			@(posedge clk);
			@(negedge clk);
			chk8(rd_data, cur[c]);
		end
	endtask
	// a write offered in shutdown must not reach the device
	task t_shutdown;
		@(posedge clk);
		cmd_power_down <= 1'h1;
		repeat (2) @(negedge clk);
		chk1(s_oe, 1'h0);
		chk1(pd, 1'h1);
		chk8(chan[7:0], 8'hZZ);
		@(posedge clk);
		cmd_write <= 1'h1;
		cmd_data <= 8'h77;
		repeat (3) @(negedge clk);
		chk1(wr_n, 1'h1);
		@(posedge clk);
		cmd_write <= 1'h0;
		cmd_power_down <= 1'h0;
		repeat (2) @(negedge clk);
		chk1(s_oe, 1'h1);
		for (int c = 0; c < 4; c++)
			chk8(chan[c*8+:8], cur[c]);
	endtask

	// ==========
	// main sequence
	initial begin
		reset = 1'h1;
		cmd_write = 1'h0;
		cmd_update = 1'h0;
		cmd_power_down = 1'h0;
		cmd_channel = 2'h0;
		cmd_data = 8'h00;
		rd_channel = 2'h0;
		err_total = 0;
		checked = 0;
		// bitwise inversion of any code gives a different code
		cur = '{8'h80, 8'h01, 8'hC4, 8'h1E};
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		@(negedge clk);
		t_reset;
		t_write_load;
		t_preload;
		t_readback;
		t_shutdown;
		results;
	end
endmodule
